// *** hw/lpr_pkg.sv ***
// constants, command carrier and helpers for the refresh scheduling block
// assumes a single 100 MHz core clock that also samples the command bus
package lpr_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 100;
  localparam int NS_PER_US = 1000;
  localparam int RFCAB_NS_DEF = 130;
  localparam int RFCPB_NS_DEF = 60;
  localparam int BURST_FACTOR = 4;
  localparam int BURST_MAX = 8;
  localparam int EIGHT_BANKS = 8;

  // ==========================================================================
  // widths and command field positions
  // ==========================================================================
  localparam int BANK_W = 3;
  localparam int TMR_W = 8;
  localparam int STAMP_W = 32;
  localparam int SPTR_W = 3;
  localparam int SCNT_W = 4;
  localparam int CA_W = 4;
  localparam int CA_BIT0 = 0;
  localparam int CA_BIT1 = 1;
  localparam int CA_BIT2 = 2;
  localparam int CA_BIT3 = 3;

  typedef struct packed {
    logic cs_n;
    logic [CA_W-1:0] ca;
  } lpr_ca_t;

  // least time in cycles, rounded up, never below one
  function automatic int lpr_cyc_ceil(input int ns);
    int c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    return (c < 1) ? 1 : c;
  endfunction : lpr_cyc_ceil

  // refresh command: select low, bit0 low, bit1 low, bit2 high
  function automatic logic lpr_is_refresh(input lpr_ca_t c);
    return !c.cs_n && !c.ca[CA_BIT0] && !c.ca[CA_BIT1] && c.ca[CA_BIT2];
  endfunction : lpr_is_refresh

endpackage : lpr_pkg

// *** hw/lpr_refresh.sv ***
// device-side refresh command handling: decode, bank counter, busy tracking
// assumes command bus is sampled on I_CORE_CLK; reset/self-refresh-exit are
// decoded elsewhere and arrive as one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none

module lpr_refresh #(
  parameter int NUM_BANKS = lpr_pkg::EIGHT_BANKS,
  parameter int RFCAB_NS = lpr_pkg::RFCAB_NS_DEF,
  parameter int RFCPB_NS = lpr_pkg::RFCPB_NS_DEF
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire lpr_pkg::lpr_ca_t I_CA_CMD,
  input wire logic I_RESET_CMD,
  input wire logic I_SREF_EXIT,
  output logic [lpr_pkg::BANK_W-1:0] O_REF_BANK,
  output logic O_PB_REFRESH,
  output logic O_AB_REFRESH,
  output logic [NUM_BANKS-1:0] O_BANK_BUSY,
  output logic O_TIMING_ERROR,
  output logic O_BURST_ERROR
);

  // ==========================================================================
  // derived cycle counts
  // ==========================================================================
  localparam int RFCAB_CYC = lpr_pkg::lpr_cyc_ceil(RFCAB_NS);
  localparam int RFCPB_CYC = lpr_pkg::lpr_cyc_ceil(RFCPB_NS);
  localparam int BURST_WIN_CYC = lpr_pkg::BURST_FACTOR * lpr_pkg::BURST_MAX * RFCAB_CYC;
  localparam logic [lpr_pkg::TMR_W-1:0] AB_LOAD = lpr_pkg::TMR_W'(RFCAB_CYC - 1);
  localparam logic [lpr_pkg::TMR_W-1:0] PB_LOAD = lpr_pkg::TMR_W'(RFCPB_CYC - 1);
  localparam logic [lpr_pkg::STAMP_W-1:0] BURST_WIN = lpr_pkg::STAMP_W'(BURST_WIN_CYC);
  localparam logic [lpr_pkg::BANK_W-1:0] LAST_BANK = lpr_pkg::BANK_W'(NUM_BANKS - 1);
  localparam logic [lpr_pkg::SCNT_W-1:0] SCNT_FULL = lpr_pkg::SCNT_W'(lpr_pkg::BURST_MAX);
  localparam logic PB_ALLOWED = (NUM_BANKS == lpr_pkg::EIGHT_BANKS);

  // ==========================================================================
  // state
  // ==========================================================================
  logic [lpr_pkg::TMR_W-1:0] ab_tmr, next_ab_tmr, pb_tmr, next_pb_tmr;
  logic [lpr_pkg::BANK_W-1:0] ref_bank, next_ref_bank, pb_bank, next_pb_bank;
  logic [NUM_BANKS-1:0] busy, next_busy;
  logic pb_ev, next_pb_ev, ab_ev, next_ab_ev, terr, next_terr, berr, next_berr;
  logic [lpr_pkg::STAMP_W-1:0] now, next_now;
  logic [lpr_pkg::STAMP_W-1:0] stamp [lpr_pkg::BURST_MAX];
  logic [lpr_pkg::STAMP_W-1:0] next_stamp [lpr_pkg::BURST_MAX];
  logic [lpr_pkg::SPTR_W-1:0] sptr, next_sptr;
  logic [lpr_pkg::SCNT_W-1:0] scnt, next_scnt;
  logic is_ref, want_pb, want_ab, ab_run, pb_run, pb_ok, ab_ok;

  // ==========================================================================
  // decode and acceptance
  // ==========================================================================
  always_comb begin
    is_ref = lpr_pkg::lpr_is_refresh(I_CA_CMD);
    want_pb = is_ref && !I_CA_CMD.ca[lpr_pkg::CA_BIT3];
    want_ab = is_ref && I_CA_CMD.ca[lpr_pkg::CA_BIT3];
    ab_run = (ab_tmr != '0);
    pb_run = (pb_tmr != '0);
    // spacing after prior refreshes enforced; violators are dropped
    pb_ok = want_pb && PB_ALLOWED && !ab_run && !pb_run;
    ab_ok = want_ab && !ab_run && !pb_run;
  end

  // ==========================================================================
  // timers, bank counter and busy map
  // ==========================================================================
  always_comb begin
    next_ab_tmr = ab_run ? ab_tmr - 1'b1 : ab_tmr;
    next_pb_tmr = pb_run ? pb_tmr - 1'b1 : pb_tmr;
    next_pb_bank = pb_bank;
    next_ref_bank = ref_bank;
    if (ab_ok) begin
      next_ab_tmr = AB_LOAD;
    end
    if (pb_ok) begin
      next_pb_tmr = PB_LOAD;
      next_pb_bank = ref_bank;
      next_ref_bank = (ref_bank == LAST_BANK) ? '0 : ref_bank + 1'b1;
    end
    if (I_RESET_CMD || I_SREF_EXIT || ab_ok) begin
      next_ref_bank = '0;
    end
    for (int b = 0; b < NUM_BANKS; b++) begin
      // only the per-bank target is blocked; others stay usable
      next_busy[b] = (next_ab_tmr != '0) ||
                     ((next_pb_tmr != '0) && (next_pb_bank == lpr_pkg::BANK_W'(b)));
    end
    next_pb_ev = pb_ok;
    next_ab_ev = ab_ok;
    // refresh inside a running delay, or per-bank on a small device
    next_terr = (want_pb && !pb_ok) || (want_ab && !ab_ok);
  end

  // ==========================================================================
  // burst limit: ring of the last eight all-bank issue times
  // ==========================================================================
  always_comb begin
    next_now = now + 1'b1;
    next_stamp = stamp;
    next_sptr = sptr;
    next_scnt = scnt;
    next_berr = ab_ok && (scnt == SCNT_FULL) && ((now - stamp[sptr]) < BURST_WIN);
    if (ab_ok) begin
      next_stamp[sptr] = now;
      next_sptr = sptr + 1'b1;
      if (scnt != SCNT_FULL) begin
        next_scnt = scnt + 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ab_tmr <= '0;
      pb_tmr <= '0;
      pb_bank <= '0;
      ref_bank <= '0;
      busy <= '0;
      pb_ev <= 1'b0;
      ab_ev <= 1'b0;
      terr <= 1'b0;
      berr <= 1'b0;
      now <= '0;
      for (int i = 0; i < lpr_pkg::BURST_MAX; i++) begin
        stamp[i] <= '0;
      end
      sptr <= '0;
      scnt <= '0;
    end else begin
      ab_tmr <= next_ab_tmr;
      pb_tmr <= next_pb_tmr;
      pb_bank <= next_pb_bank;
      ref_bank <= next_ref_bank;
      busy <= next_busy;
      pb_ev <= next_pb_ev;
      ab_ev <= next_ab_ev;
      terr <= next_terr;
      berr <= next_berr;
      now <= next_now;
      stamp <= next_stamp;
      sptr <= next_sptr;
      scnt <= next_scnt;
    end
  end

  assign O_REF_BANK = ref_bank;
  assign O_PB_REFRESH = pb_ev;
  assign O_AB_REFRESH = ab_ev;
  assign O_BANK_BUSY = busy;
  assign O_TIMING_ERROR = terr;
  assign O_BURST_ERROR = berr;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  a_pb_decode: assert property (want_pb && PB_ALLOWED && !ab_run && !pb_run
    |=> O_PB_REFRESH && !O_AB_REFRESH) else $error("per-bank refresh not taken");
  a_ab_decode: assert property (want_ab && !ab_run && !pb_run
    |=> O_AB_REFRESH && !O_PB_REFRESH) else $error("all-bank refresh not taken");
  a_pb_small_dev: assert property (!PB_ALLOWED && want_pb
    |=> !O_PB_REFRESH && O_TIMING_ERROR) else $error("per-bank accepted on small device");
  a_ctr_advance: assert property (pb_ok && !I_RESET_CMD && !I_SREF_EXIT
    |=> O_REF_BANK == (($past(ref_bank) == LAST_BANK) ? '0 : $past(ref_bank) + 1'b1))
    else $error("bank counter did not advance");
  a_ctr_zero: assert property (ab_ok || I_RESET_CMD || I_SREF_EXIT
    |=> O_REF_BANK == '0) else $error("bank counter not cleared");
  a_only_target: assert property (pb_ok
    |=> O_BANK_BUSY == (NUM_BANKS'(1) << $past(ref_bank)) || RFCPB_CYC == 1)
    else $error("non-target bank marked busy");
  a_ab_hold: assert property (ab_ok |=> (O_BANK_BUSY == '1)[*8])
    else $error("all-bank busy dropped early");
  a_delay_flag: assert property ((want_ab || want_pb) && ab_run
    |=> O_TIMING_ERROR && !O_AB_REFRESH && !O_PB_REFRESH)
    else $error("refresh during delay not flagged");
  a_burst_flag: assert property (O_BURST_ERROR |-> O_AB_REFRESH)
    else $error("burst error without all-bank refresh");
  a_pb_spacing: assert property ((want_ab || want_pb) && pb_run
    |=> O_TIMING_ERROR && !O_AB_REFRESH && !O_PB_REFRESH)
    else $error("refresh during per-bank delay not flagged");
  a_idle_quiet: assert property (!is_ref
    |=> !O_PB_REFRESH && !O_AB_REFRESH && !O_TIMING_ERROR)
    else $error("refresh pulse without refresh command");
  a_ctr_hold: assert property (!pb_ok && !ab_ok && !I_RESET_CMD && !I_SREF_EXIT
    |=> $stable(O_REF_BANK))
    else $error("bank counter moved without cause");

  c_pb_wrap: cover property (pb_ok && ref_bank == LAST_BANK);
  c_ab_after_pb: cover property (O_PB_REFRESH ##[1:40] O_AB_REFRESH);
  c_burst_err: cover property (O_BURST_ERROR);
  c_timing_err: cover property (O_TIMING_ERROR);
  c_sync_clear: cover property ((I_RESET_CMD || I_SREF_EXIT) && ref_bank != '0);

endmodule : lpr_refresh

`default_nettype wire

// *** dv/lpr_ctrl_model.sv ***
// partner model: controller issuing refresh commands on the command bus
// assumes its tasks are entered at a falling edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module lpr_ctrl_model (
  input wire logic i_clk,
  output var lpr_pkg::lpr_ca_t o_ca
);
  localparam int AB_CYC = (lpr_pkg::RFCAB_NS_DEF + 9) / 10;
  localparam int PB_CYC = (lpr_pkg::RFCPB_NS_DEF + 9) / 10;
  localparam int WIN = 4 * 8 * AB_CYC;
  int cyc = 0;
  int last_ab = -1000;
  int last_pb = -1000;
  int stamps[$];
  bit hang = 0;
  int credit = 0;
  int pb_round = 0;
  time rel_t = '1;
  initial o_ca = 5'h1B;
  always @(posedge i_clk) cyc <= cyc + 1;
  // ==========================================================================
  // no activates issued, so every bank is idle
  // no self-refresh entered, one distributed pattern
  // mode 0 legal, 1 ignores burst limit, 2 ignores spacing and burst limit
  task automatic issue(input bit all, input int mode, output bit ok, output bit burst);
    int t;
    int n;
    bit room;
    n = 0;
    if ($time == rel_t) @(negedge i_clk);
    forever begin
      t = cyc + 1;
      ok = t - last_ab >= AB_CYC && t - last_pb >= PB_CYC;
      room = !all || stamps.size() < 8 || t - stamps[stamps.size()-8] >= WIN;
      if (mode == 2 || (ok && (mode == 1 || room)) || n > 1000) break;
      n++;
      @(negedge i_clk);
    end
    hang |= n > 1000;
    burst = all && ok && !room;
    o_ca = '{cs_n: 1'b0, ca: {all, 3'b100}};
    if (ok && all) begin
      last_ab = t;
      stamps.push_back(t);
      credit++;
      pb_round = 0;
    end
    if (ok && !all) begin
      last_pb = t;
      pb_round++;
    end
    if (pb_round == lpr_pkg::EIGHT_BANKS) begin
      credit++;
      pb_round = 0;
    end
    release_bus();
  endtask : issue
  // released bus deselects and shows the inverse of the last CA value
  task automatic release_bus();
    @(negedge i_clk);
    o_ca = '{cs_n: 1'b1, ca: ~o_ca.ca};
    rel_t = $time;
  endtask : release_bus
  task automatic noise(input logic [4:0] v);
    lpr_pkg::lpr_ca_t c;
    if ($time == rel_t) @(negedge i_clk);
    c = v;
    if (!c.cs_n && c.ca[2:0] == 3'b100) c.cs_n = 1'b1;
    o_ca = c;
    release_bus();
  endtask : noise
  // bank counter resynchronised by reset command or self-refresh exit
  task automatic resync();
    pb_round = 0;
  endtask : resync
endmodule : lpr_ctrl_model
`default_nettype wire

// *** dv/tb_top.sv ***
// bench: directed and random refresh traffic against the refresh block
// assumes the partner model drives the command bus at falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, rst, reset_cmd, sref_exit;
  lpr_pkg::lpr_ca_t ca_cmd;
  logic [lpr_pkg::BANK_W-1:0] ref_bank;
  logic [7:0] busy;
  logic pb, ab, terr, berr, terr4;
  int failures = 0;
  int total_checks = 0;
  int exp_bank = 0;
  int dut_credit = 0;
  bit ok, bst;
  lpr_ctrl_model M (.i_clk(core_clk), .o_ca(ca_cmd));
  lpr_refresh DUT (.I_CORE_CLK(core_clk), .I_RST(rst), .I_CA_CMD(ca_cmd),
    .I_RESET_CMD(reset_cmd), .I_SREF_EXIT(sref_exit), .O_REF_BANK(ref_bank),
    .O_PB_REFRESH(pb), .O_AB_REFRESH(ab), .O_BANK_BUSY(busy),
    .O_TIMING_ERROR(terr), .O_BURST_ERROR(berr));
  lpr_refresh #(.NUM_BANKS(4)) DUT4 (.I_CORE_CLK(core_clk), .I_RST(rst),
    .I_CA_CMD(ca_cmd), .I_RESET_CMD(reset_cmd), .I_SREF_EXIT(sref_exit),
    .O_REF_BANK(), .O_PB_REFRESH(), .O_AB_REFRESH(), .O_BANK_BUSY(),
    .O_TIMING_ERROR(terr4), .O_BURST_ERROR());
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  function automatic int next_bank(input bit all, input int b);
    return all ? 0 : (b + 1) % lpr_pkg::EIGHT_BANKS;
  endfunction : next_bank
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic do_ref(input bit all, input int mode);
    logic [7:0] eb;
    M.issue(all, mode, ok, bst);
    eb = all ? 8'hFF : (8'h01 << exp_bank);
    check(pb, ok && !all);
    check(ab, ok && all);
    check(terr, !ok);
    check(berr, bst);
    if (ok) begin
      exp_bank = next_bank(all, exp_bank);
      check(busy, eb);
    end
    check(ref_bank, exp_bank);
    if (ab || (pb && ref_bank == '0)) dut_credit++;
    if (!all) check(terr4, 1'b1);
  endtask : do_ref
  task automatic busy_len(input int n, input logic [7:0] v);
    repeat (n - 2) @(negedge core_clk);
    check(busy, v);
    @(negedge core_clk);
    check(busy, 0);
  endtask : busy_len
  task automatic sync_pulse(input bit which);
    if (which) reset_cmd = 1'b1;
    else sref_exit = 1'b1;
    @(negedge core_clk);
    reset_cmd = 1'b0;
    sref_exit = 1'b0;
    @(negedge core_clk);
    exp_bank = 0;
    M.resync();
    check(ref_bank, 0);
  endtask : sync_pulse
  // ==========================================================================
  initial begin
    rst = 1'b1;
    reset_cmd = 1'b0;
    sref_exit = 1'b0;
    void'($urandom(22));
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    check({pb, ab, terr, berr, busy, ref_bank}, 0);
    @(negedge core_clk);
    do_ref(0, 0);
    busy_len(6, 8'h01);
    do_ref(0, 0);
    do_ref(0, 2);
    do_ref(1, 0);
    busy_len(13, 8'hFF);
    repeat (9) do_ref(1, 1);
    do_ref(0, 0);
    sync_pulse(1);
    do_ref(0, 0);
    sync_pulse(0);
    $display("test directed done");
    repeat (300) begin
      case ($urandom % 8)
        0, 1, 2, 3: do_ref(0, ($urandom % 4 == 0) ? 2 : 0);
        4: do_ref(1, 0);
        5: sync_pulse($urandom % 2);
        default: begin
          M.noise(5'($urandom));
          check({pb, ab, terr}, 0);
        end
      endcase
    end
    check(M.hang, 0);
    check(M.credit, dut_credit);
    $display("test random done");
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
